// ===== asbp_uart.sv
// serial port top: registers, transmitter, receive holding and flags
// Contract
// R1: full duplex asynchronous port with only variable-rate modes one and three.
// R2: completed byte is held so the next frame can shift in.
// R3: one data address: writes go to transmit, reads return receive holding.
// R4: done flags stay set until software clears them.
// R5: bit clocks are the timer overflows halved, for transmit and receive.
// R6: receive timer copy shares reload and restarts on start detect.
// R7: overflow rate is timer clock over 256 minus reload; bit rate half.
// R8: timer clock from system clock /4, /12, /48, oscillator /8, or count pin.
// R9: frame format chosen by control bit seven.
// R10: select zero gives 8-bit frames, one gives 9-bit frames.
// R11: 8-bit frame: start, eight data bits LSB first, stop.
// R12: data write starts transmit; done flag set at start of stop bit.
// R13: receiver accepts frames only while receive enable is set; code checks it only at start detect.
// R14: 8-bit capture needs done clear and, if checked, stop bit one.
// R15: on overrun the earlier byte stays and the new frame is lost.
// R16: 9-bit frame adds ninth bit from transmit extra control bit.
// R17: 9-bit capture stores ninth bit; needs done clear and address check.
// R18: interrupt request whenever a done flag is set, if enabled.
// R19: software sets transmit extra bit before writing a 9-bit byte.
// R20: bits sampled mid-period from start reload; short start is noise.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module asbp_uart
  import asbp_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic irq_enable_in,
  output logic irq_out,
  input wire logic ext_osc_in,
  input wire logic external_count_input,
  input wire logic serial_in_pin,
  output logic serial_out_pin
);
  logic rst_a_q, rst_b_q;
  logic [7:0] ctrl_q, ctrl_d, rxbuf_q, rxbuf_d, txsh_q, txsh_d;
  logic [7:0] reload_q, reload_d, tmr_q, tmr_d, rdata_q, rdata_d;
  asbp_state_t tst_q, tst_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic tph_q, tph_d, out_q, out_d;
  logic [7:0] baud_count;
  logic tx_ovf, rx_ovf, rx_restart, rx_done_ev, rx_extra;
  logic [7:0] rx_data;
  logic accept;
  logic tx_set;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end

  asbp_baud u_baud (
    .clk_in(clk_in),
    .rst_n_in(rst_b_q),
    .run_in(tmr_q[BIT_TMR_RUN]),
    .src_in(tmr_q[TMR_SRC_LSB +: 3]),
    .reload_in(reload_q), // see R7
    .ext_osc_in(ext_osc_in),
    .ext_count_in(external_count_input),
    .rx_restart_in(rx_restart),
    .count_out(baud_count),
    .tx_ovf_out(tx_ovf),
    .rx_ovf_out(rx_ovf)
  );

  asbp_rx u_rx ( // see R1
    .clk_in(clk_in),
    .rst_n_in(rst_b_q),
    .enable_in(ctrl_q[BIT_RX_EN]),
    .nine_bit_in(ctrl_q[BIT_FRAME_SEL]), // see R10
    .serial_in_pin(serial_in_pin),
    .rx_ovf_in(rx_ovf),
    .restart_out(rx_restart),
    .frame_done_out(rx_done_ev),
    .frame_data_out(rx_data),
    .frame_extra_out(rx_extra)
  );

  // capture conditions: done clear and, if checking, extra bit (stop or ninth) one
  assign accept = rx_done_ev && !ctrl_q[BIT_RX_DONE]
                  && (!ctrl_q[BIT_CHECK_EN] || rx_extra); // see R14 see R17 see R15

  // one bus write strobe aimed at one register
  function automatic logic wr_hit(input logic wr, input logic [1:0] a, input logic [1:0] reg_a);
    return wr && (a == reg_a);
  endfunction

  // transmitter, one-hot state, a bit spans two overflows
  always_comb begin
    tst_d = tst_q;
    tx_set = 1'b0;
    tcnt_d = tcnt_q;
    tph_d = tph_q;
    txsh_d = txsh_q;
    out_d = out_q;
    ctrl_d = ctrl_q;
    case (tst_q)
      ASBP_IDLE: begin
        out_d = 1'b1;
        if (wr_hit(wr_in, addr_in, ADDR_DATA)) begin // see R12 see R3
          txsh_d = wdata_in;
          tst_d = ASBP_SHIFT;
          tcnt_d = 4'h0;
          tph_d = 1'b0;
        end
      end
      ASBP_SHIFT: begin
        if (tx_ovf) begin
          tph_d = !tph_q; // see R5
          if (!tph_q) begin
            tcnt_d = tcnt_q + 4'h1;
            if (tcnt_q == 4'h0) begin
              out_d = 1'b0;
            end else if (tcnt_q <= 4'h8) begin
              out_d = txsh_q[0]; // see R11
              txsh_d = {1'b0, txsh_q[7:1]};
            end else if (tcnt_q == 4'h9 && ctrl_q[BIT_FRAME_SEL]) begin
              out_d = ctrl_q[BIT_TX_EXTRA]; // see R16 see R19
            end else begin
              out_d = 1'b1;
              ctrl_d[BIT_TX_DONE] = 1'b1; // see R12
              tx_set = 1'b1;
              tst_d = ASBP_STOP;
            end
          end
        end
      end
      ASBP_STOP: begin
        if (tx_ovf) begin
          tph_d = !tph_q;
          if (tph_q) tst_d = ASBP_IDLE;
        end
      end
      default: tst_d = ASBP_IDLE;
    endcase
    // software writes to control; hardware sets win over clears, see R4
    if (wr_hit(wr_in, addr_in, ADDR_CTRL)) begin
      ctrl_d = {wdata_in[7], 1'b1, wdata_in[5:2], wdata_in[1] | tx_set, wdata_in[0]}; // see R9
    end
    rxbuf_d = rxbuf_q;
    if (accept) begin
      rxbuf_d = rx_data; // see R2
      ctrl_d[BIT_RX_EXTRA] = rx_extra;
      ctrl_d[BIT_RX_DONE] = 1'b1;
    end
    reload_d = wr_hit(wr_in, addr_in, ADDR_RELOAD) ? wdata_in : reload_q;
    tmr_d = wr_hit(wr_in, addr_in, ADDR_TIMER) ? wdata_in : tmr_q;
    case (addr_in)
      ADDR_CTRL: rdata_d = ctrl_q;
      ADDR_DATA: rdata_d = rxbuf_q; // see R3
      ADDR_RELOAD: rdata_d = reload_q;
      default: rdata_d = baud_count;
    endcase
    if (!rd_in) rdata_d = 8'h00;
  end

  always_ff @(posedge clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      ctrl_q <= CTRL_RESET;
      rxbuf_q <= DATA_RESET;
      txsh_q <= DATA_RESET;
      reload_q <= TIMER_RESET;
      tmr_q <= TIMER_RESET;
      rdata_q <= 8'h00;
      tst_q <= ASBP_IDLE;
      tcnt_q <= 4'h0;
      tph_q <= 1'b0;
      out_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      rxbuf_q <= rxbuf_d;
      txsh_q <= txsh_d;
      reload_q <= reload_d;
      tmr_q <= tmr_d;
      rdata_q <= rdata_d;
      tst_q <= tst_d;
      tcnt_q <= tcnt_d;
      tph_q <= tph_d;
      out_q <= out_d;
    end
  end

  assign rdata_out = rdata_q;
  assign serial_out_pin = out_q;
  assign irq_out = irq_enable_in && (ctrl_q[BIT_TX_DONE] || ctrl_q[BIT_RX_DONE]); // see R18

  property p_rx_flag_sticky;
    @(posedge clk_in) disable iff (!rst_b_q)
    ctrl_q[BIT_RX_DONE] && !(wr_in && addr_in == ADDR_CTRL) |=> ctrl_q[BIT_RX_DONE];
  endproperty
  a_rx_flag_sticky: assert property (p_rx_flag_sticky) else $error("rx done dropped"); // see R4
  property p_overrun_keep;
    @(posedge clk_in) disable iff (!rst_b_q)
    rx_done_ev && ctrl_q[BIT_RX_DONE] |=> $stable(rxbuf_q);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("overrun replaced byte"); // see R15
  property p_capture;
    @(posedge clk_in) disable iff (!rst_b_q)
    accept |=> rxbuf_q == $past(rx_data) && ctrl_q[BIT_RX_DONE];
  endproperty
  a_capture: assert property (p_capture) else $error("byte not captured"); // see R2
  property p_check_block;
    @(posedge clk_in) disable iff (!rst_b_q)
    rx_done_ev && ctrl_q[BIT_CHECK_EN] && !rx_extra && !ctrl_q[BIT_RX_DONE]
      && !(wr_in && addr_in == ADDR_CTRL) |=> !ctrl_q[BIT_RX_DONE];
  endproperty
  a_check_block: assert property (p_check_block) else $error("check ignored"); // see R14
  property p_tx_start;
    @(posedge clk_in) disable iff (!rst_b_q)
    tst_q == ASBP_IDLE && wr_in && addr_in == ADDR_DATA |=> tst_q == ASBP_SHIFT;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start tx"); // see R12
  property p_tx_done_stop;
    @(posedge clk_in) disable iff (!rst_b_q)
    $rose(tst_q == ASBP_STOP) |-> ctrl_q[BIT_TX_DONE] && serial_out_pin;
  endproperty
  a_tx_done_stop: assert property (p_tx_done_stop) else $error("tx done late"); // see R12
  property p_idle_high;
    @(posedge clk_in) disable iff (!rst_b_q)
    tst_q == ASBP_IDLE |-> serial_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low in idle"); // see R11
  property p_irq;
    @(posedge clk_in) disable iff (!rst_b_q)
    irq_enable_in && $rose(ctrl_q[BIT_TX_DONE]) |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("missing irq"); // see R18
  property p_rx_disabled;
    @(posedge clk_in) disable iff (!rst_b_q)
    !ctrl_q[BIT_RX_EN] |-> !rx_restart;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled) else $error("rx while disabled"); // see R13
  property p_tx_clear;
    @(posedge clk_in) disable iff (!rst_b_q)
    wr_in && addr_in == ADDR_CTRL && !wdata_in[BIT_TX_DONE] && !tx_set
      |=> !ctrl_q[BIT_TX_DONE];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx done not cleared"); // see R4
  property p_tx_set_wins;
    @(posedge clk_in) disable iff (!rst_b_q)
    tx_set |=> ctrl_q[BIT_TX_DONE];
  endproperty
  a_tx_set_wins: assert property (p_tx_set_wins) else $error("tx done set lost"); // see R4
  property p_unused_one;
    @(posedge clk_in) disable iff (!rst_b_q)
    ctrl_q[BIT_UNUSED];
  endproperty
  a_unused_one: assert property (p_unused_one) else $error("unused bit not one"); // see R9
  property p_rdata_idle;
    @(posedge clk_in) disable iff (!rst_b_q)
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read"); // see R3
  property p_data_read;
    @(posedge clk_in) disable iff (!rst_b_q)
    rd_in && addr_in == ADDR_DATA |=> rdata_out == $past(rxbuf_q);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read not holding"); // see R3
  property p_start_low;
    @(posedge clk_in) disable iff (!rst_b_q)
    tst_q == ASBP_SHIFT && tx_ovf && !tph_q && tcnt_q == 4'h0 |=> !serial_out_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // see R11
  property p_ninth_bit;
    @(posedge clk_in) disable iff (!rst_b_q)
    tst_q == ASBP_SHIFT && tx_ovf && !tph_q && tcnt_q == 4'h9 && ctrl_q[BIT_FRAME_SEL]
      |=> serial_out_pin == $past(ctrl_q[BIT_TX_EXTRA]);
  endproperty
  a_ninth_bit: assert property (p_ninth_bit) else $error("ninth bit wrong"); // see R16
  property p_bit_hold;
    @(posedge clk_in) disable iff (!rst_b_q)
    tst_q == ASBP_SHIFT && !(tx_ovf && !tph_q) |=> $stable(serial_out_pin);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit changed mid period"); // see R5
  property p_rx_extra_load;
    @(posedge clk_in) disable iff (!rst_b_q)
    accept |=> ctrl_q[BIT_RX_EXTRA] == $past(rx_extra);
  endproperty
  a_rx_extra_load: assert property (p_rx_extra_load) else $error("extra bit lost"); // see R14 see R17
  property p_reload_write;
    @(posedge clk_in) disable iff (!rst_b_q)
    wr_in && addr_in == ADDR_RELOAD |=> reload_q == $past(wdata_in);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload not written"); // see R7
  property p_timer_write;
    @(posedge clk_in) disable iff (!rst_b_q)
    wr_in && addr_in == ADDR_TIMER |=> tmr_q == $past(wdata_in);
  endproperty
  a_timer_write: assert property (p_timer_write) else $error("timer control not written"); // see R8
  property p_irq_off;
    @(posedge clk_in) disable iff (!rst_b_q)
    !irq_enable_in |-> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled"); // see R18
  c_tx_frame: cover property (@(posedge clk_in) $rose(ctrl_q[BIT_TX_DONE]));
  c_rx_frame: cover property (@(posedge clk_in) accept);
  c_overrun: cover property (@(posedge clk_in) rx_done_ev && ctrl_q[BIT_RX_DONE]);
  c_nine_frame: cover property (@(posedge clk_in) accept && ctrl_q[BIT_FRAME_SEL]);
  c_tx_clear: cover property (@(posedge clk_in) ctrl_q[BIT_TX_DONE] ##1 !ctrl_q[BIT_TX_DONE]);
endmodule // asbp_uart
`default_nettype wire

// ===== asbp_pkg.sv
// package: register map, control bits and timing constants of the serial port
package asbp_pkg;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_RELOAD = 2'h2;
  localparam logic [1:0] ADDR_TIMER = 2'h3;
  localparam int BIT_FRAME_SEL = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_CHECK_EN = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX_EXTRA = 3;
  localparam int BIT_RX_EXTRA = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // timer control: [0] run, [3:1] clock source
  localparam int BIT_TMR_RUN = 0;
  localparam int TMR_SRC_LSB = 1;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [2:0] SRC_DIV4 = 3'h0;
  localparam logic [2:0] SRC_DIV12 = 3'h1;
  localparam logic [2:0] SRC_DIV48 = 3'h2;
  localparam logic [2:0] SRC_EXTOSC8 = 3'h3;
  localparam logic [2:0] SRC_EXTCNT = 3'h4;
  localparam logic [5:0] DIV4_COUNT = 6'h04;
  localparam logic [5:0] DIV12_COUNT = 6'h0C;
  localparam logic [5:0] DIV48_COUNT = 6'h30;
  localparam logic [2:0] EXTOSC_DIV = 3'h7;
  localparam logic [3:0] BITS_8 = 4'h9;
  localparam logic [3:0] BITS_9 = 4'hA;
  typedef enum logic [2:0] {
    ASBP_IDLE = 3'b001,
    ASBP_SHIFT = 3'b010,
    ASBP_STOP = 3'b100
  } asbp_state_t;
endpackage : asbp_pkg

// ===== asbp_baud.sv
// baud timer: 8-bit auto-reload counter with a private receive copy
`timescale 1ns/10ps
`default_nettype none
module asbp_baud
  import asbp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [2:0] src_in,
  input wire logic [7:0] reload_in,
  input wire logic ext_osc_in,
  input wire logic ext_count_in,
  input wire logic rx_restart_in,
  output logic [7:0] count_out,
  output logic tx_ovf_out,
  output logic rx_ovf_out
);
  logic [5:0] pre_q, pre_d;
  logic [2:0] osc_q, osc_d;
  logic osc_s_q, osc_d_q, cnt_s_q, cnt_d_q;
  logic [7:0] tl_q, tl_d, rxt_q, rxt_d;
  logic tick;
  logic [5:0] div;

  always_comb begin
    case (src_in)
      SRC_DIV12: div = DIV12_COUNT;
      SRC_DIV48: div = DIV48_COUNT;
      default: div = DIV4_COUNT;
    endcase
    pre_d = (pre_q >= div - 6'h01) ? 6'h00 : pre_q + 6'h01;
    osc_d = osc_q + 3'h1;
    if (!(osc_s_q && !osc_d_q)) osc_d = osc_q;
    case (src_in) // see R8
      SRC_DIV4, SRC_DIV12, SRC_DIV48: tick = (pre_q >= div - 6'h01);
      SRC_EXTOSC8: tick = osc_s_q && !osc_d_q && (osc_q == EXTOSC_DIV);
      SRC_EXTCNT: tick = cnt_s_q && !cnt_d_q;
      default: tick = 1'b0;
    endcase
    tick = tick && run_in;
    tl_d = tl_q;
    rxt_d = rxt_q;
    tx_ovf_out = tick && (tl_q == 8'hFF);
    rx_ovf_out = tick && (rxt_q == 8'hFF);
    if (tick) begin // see R5
      tl_d = tx_ovf_out ? reload_in : tl_q + 8'h01;
      rxt_d = rx_ovf_out ? reload_in : rxt_q + 8'h01; // see R6
    end
    if (rx_restart_in) begin
      rxt_d = reload_in; // see R6
      rx_ovf_out = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= 6'h00;
      osc_q <= 3'h0;
      osc_s_q <= 1'b0;
      osc_d_q <= 1'b0;
      cnt_s_q <= 1'b0;
      cnt_d_q <= 1'b0;
      tl_q <= 8'h00;
      rxt_q <= 8'h00;
    end else begin
      pre_q <= pre_d;
      osc_q <= osc_d;
      osc_s_q <= ext_osc_in;
      osc_d_q <= osc_s_q;
      cnt_s_q <= ext_count_in;
      cnt_d_q <= cnt_s_q;
      tl_q <= tl_d;
      rxt_q <= rxt_d;
    end
  end
  assign count_out = tl_q;
endmodule // asbp_baud
`default_nettype wire

// ===== asbp_rx.sv
// receive shifter: start detect, mid-bit sampling, frame capture
`timescale 1ns/10ps
`default_nettype none
module asbp_rx
  import asbp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic nine_bit_in,
  input wire logic serial_in_pin,
  input wire logic rx_ovf_in,
  output logic restart_out,
  output logic frame_done_out,
  output logic [7:0] frame_data_out,
  output logic frame_extra_out
);
  asbp_state_t st_q, st_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic ph_q, ph_d;
  logic line_q;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    restart_out = 1'b0;
    frame_done_out = 1'b0;
    case (st_q)
      ASBP_IDLE: begin
        if (enable_in && line_q && !serial_in_pin) begin // see R13
          restart_out = 1'b1; // see R6
          st_d = ASBP_SHIFT;
          cnt_d = 4'h0;
          ph_d = 1'b0;
        end
      end
      ASBP_SHIFT: begin
        if (rx_ovf_in) begin
          ph_d = !ph_q; // see R5
          if (!ph_q) begin // first overflow is mid-bit, see R20
            if (cnt_q == 4'h0 && serial_in_pin) begin
              st_d = ASBP_IDLE; // see R20
            end else begin
              if (cnt_q != 4'h0) sh_d = {serial_in_pin, sh_q[8:1]}; // see R11
              cnt_d = cnt_q + 4'h1;
              if (cnt_q == (nine_bit_in ? BITS_9 : BITS_8)) begin
                frame_done_out = 1'b1;
                st_d = ASBP_IDLE;
              end
            end
          end
        end
      end
      default: st_d = ASBP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ASBP_IDLE;
      sh_q <= 9'h000;
      cnt_q <= 4'h0;
      ph_q <= 1'b0;
      line_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      line_q <= serial_in_pin;
    end
  end

  // 8-bit frame: shifter holds {d7..d0} in [8:1], stop read from the pin; 9-bit: {ninth,d7..d0} before stop
  always_comb begin
    if (nine_bit_in) begin
      frame_data_out = sh_q[7:0];
      frame_extra_out = sh_q[8];
    end else begin
      frame_data_out = sh_q[8:1];
      frame_extra_out = serial_in_pin;
    end
    if (!nine_bit_in) frame_data_out = {sh_q[8:1]};
  end
endmodule // asbp_rx
`default_nettype wire

// ===== asbp_peer.sv
// far-side serial transceiver model: frame sender and frame decoder
`timescale 1ns/10ps
`default_nettype none
module asbp_peer #(
  parameter int BIT_CLKS = 24
) (
  input wire logic clk_in,
  input wire logic nine_in,
  input wire logic line_in,
  output logic line_out,
  output logic got_out,
  output logic [8:0] bits_out
);
  initial begin
    line_out = 1'b1;
    got_out = 1'b0;
    bits_out = 9'h000;
  end

  // start, data lsb first, ninth bit in 9-bit frames, stop, then idle: one bit in both formats
  task automatic send(input logic [7:0] d, input logic x, input logic stp);
    logic [10:0] f;
    f = nine_in ? {stp, x, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (nine_in ? 11 : 10); i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_in);
  endtask

  // a low pulse shorter than half a bit
  task automatic glitch(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (BIT_CLKS * 11) @(posedge clk_in);
  endtask

  // decode: eight data bits, then stop (8-bit) or ninth bit (9-bit), mid-bit
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      bits_out[i] = line_in;
    end
    got_out <= 1'b1;
    @(posedge clk_in);
    got_out <= 1'b0;
  end
endmodule // asbp_peer
`default_nettype wire

// ===== tb_asbp_uart.sv
// self-checking bench for the serial port: register bus, transmit and receive frames
`timescale 1ns/10ps
`default_nettype none
module tb_asbp_uart
  import asbp_pkg::*;
();
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_en = 1'b0;
  logic ext_osc = 1'b0;
  logic ext_cnt = 1'b0;
  logic nine = 1'b0;
  logic rd_dly = 1'b0;
  logic [7:0] rdata;
  logic [7:0] last_rd;
  logic irq, rx_line, tx_line, got;
  logic [8:0] bits;
  logic [31:0] seed = 32'h51E72E46;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] exp_rd[$];
  logic [8:0] exp_tx[$];

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    ext_osc <= ~ext_osc;
    ext_cnt <= seed[3];
  end

  asbp_uart uut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_enable_in(irq_en), .irq_out(irq),
    .ext_osc_in(ext_osc), .external_count_input(ext_cnt), .serial_in_pin(rx_line),
    .serial_out_pin(tx_line));
  asbp_peer #(.BIT_CLKS(24)) peer (.clk_in(clk_in), .nine_in(nine), .line_in(tx_line),
    .line_out(rx_line), .got_out(got), .bits_out(bits));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) fail($sformatf("read %h expected %h", g, e));
  endtask
  task automatic cmp_frame(input logic [8:0] g, input logic [8:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("frame %h expected %h", g, e));
  endtask
  task automatic cmp_irq(input logic g, input logic e);
    num_checks++;
    if (g !== e) fail($sformatf("irq %b expected %b", g, e));
  endtask

  // result watcher: read data the cycle after the strobe, frames from the peer
  always @(posedge clk_in) begin
    logic [15:0] e;
    if (rd_dly) begin
      last_rd = rdata;
      e = exp_rd.pop_front();
      cmp_reg(rdata, e[7:0], e[15:8]);
    end
    rd_dly <= rd;
    if (got) cmp_frame(bits, exp_tx.pop_front());
  end

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    exp_rd.push_back({m, e});
    @(posedge clk_in);
    rd <= 1'b0;
  endtask
  task automatic wait_flag(input int b, input int lim);
    for (int i = 0; i < lim; i++) begin
      rreg(ADDR_CTRL, 8'h00, 8'h00);
      repeat (2) @(posedge clk_in);
      if (last_rd[b] === 1'b1) return;
    end
    fail("flag wait ran out");
    complete_run();
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rreg(ADDR_CTRL, CTRL_RESET, 8'hFF);
    rreg(ADDR_DATA, DATA_RESET, 8'hFF);
    rreg(ADDR_RELOAD, 8'h00, 8'hFF);
    rreg(ADDR_TIMER, TIMER_RESET, 8'hFF);
    wreg(ADDR_CTRL, 8'h00);
    rreg(ADDR_CTRL, CTRL_RESET, 8'hFF);
    irq_en <= 1'b1;
    // same 24-clock bit from two timer sources; transmit and receive at once
    for (int s = 0; s < 2; s++) begin
      wreg(ADDR_RELOAD, s == 0 ? 8'hFD : 8'hFF);
      wreg(ADDR_TIMER, {4'h0, s == 0 ? SRC_DIV4 : SRC_DIV12, 1'b1});
      wreg(ADDR_CTRL, 8'h10);
      seed = xs(seed);
      d = seed[7:0];
      d2 = seed[15:8];
      exp_tx.push_back({1'b1, d});
      fork
        peer.send(d2, 1'b0, 1'b1);
        begin
          wreg(ADDR_DATA, d);
          wait_flag(BIT_TX_DONE, 400);
          cmp_irq(irq, 1'b1);
        end
      join
      wait_flag(BIT_RX_DONE, 200);
      rreg(ADDR_DATA, d2, 8'hFF);
      rreg(ADDR_CTRL, 8'h57, 8'hFF);
      peer.send(~d2, 1'b0, 1'b1);
      rreg(ADDR_DATA, d2, 8'hFF);
      irq_en <= 1'b0;
      @(posedge clk_in);
      cmp_irq(irq, 1'b0);
      irq_en <= 1'b1;
      wreg(ADDR_CTRL, 8'h10);
      @(posedge clk_in);
      cmp_irq(irq, 1'b0);
    end
    peer.glitch(1);
    rreg(ADDR_CTRL, 8'h00, 8'h01);
    wreg(ADDR_CTRL, 8'h00);
    peer.send(d, 1'b0, 1'b1);
    rreg(ADDR_CTRL, 8'h00, 8'h01);
    wreg(ADDR_CTRL, 8'h30);
    peer.send(d, 1'b0, 1'b0);
    rreg(ADDR_CTRL, 8'h00, 8'h01);
    // 9-bit frames: ninth bit from the control bit, address filter on receive
    nine <= 1'b1;
    for (int x = 0; x < 2; x++) begin
      seed = xs(seed);
      d = seed[7:0];
      wreg(ADDR_CTRL, x == 0 ? 8'hB0 : 8'hB8);
      exp_tx.push_back({x[0], d});
      wreg(ADDR_DATA, d);
      wait_flag(BIT_TX_DONE, 200);
      wreg(ADDR_CTRL, 8'hB0);
      // let the stop bit finish, a data write while busy is dropped
      repeat (30) @(posedge clk_in);
    end
    repeat (30) @(posedge clk_in);
    peer.send(d, 1'b0, 1'b1);
    rreg(ADDR_CTRL, 8'h00, 8'h01);
    peer.send(~d, 1'b1, 1'b0);
    wait_flag(BIT_RX_DONE, 200);
    rreg(ADDR_DATA, ~d, 8'hFF);
    rreg(ADDR_CTRL, 8'h05, 8'h05);
    repeat (50) @(posedge clk_in);
    if (exp_tx.size() != 0) fail("frames missing");
    complete_run();
  end
endmodule // tb_asbp_uart
`default_nettype wire
